// ===== logic/canis_core.sv
// CAN general interrupt flags, enables, object busy and object interrupt status
`timescale 1ns/100ps
`default_nettype none

module canis_core
	import canis_pkg::*;
#(
	parameter int NUM_OBJ = 6
) (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               sys_rst_i,
	// register port
	input  wire logic [2:0]         reg_addr_i,
	input  wire logic [7:0]         reg_wdata_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	output logic      [7:0]         reg_rdata_o,
	// protocol engine events
	input  wire logic               error_passive_i,
	input  wire logic               bus_off_i,
	input  wire logic [15:0]        timer_value_i,
	input  wire logic               timer_handler_ack_i,
	input  wire logic               frame_buffer_done_i,
	input  wire logic               buffer_config_rewritten_i,
	input  wire logic               general_stuff_error_i,
	input  wire logic               general_crc_error_i,
	input  wire logic               general_form_error_i,
	input  wire logic               general_ack_error_i,
	// message object events
	input  wire logic [NUM_OBJ-1:0] object_enable_cfg_i,
	input  wire logic [NUM_OBJ-1:0] object_disable_cfg_i,
	input  wire logic [NUM_OBJ-1:0] transmit_complete_flag_i,
	input  wire logic [NUM_OBJ-1:0] receive_complete_flag_i,
	input  wire logic [NUM_OBJ-1:0] object_error_flag_i,
	input  wire logic               abort_request_i,
	input  wire logic               standby_i,
	// interrupt requests and status view
	output logic                    can_irq_o,
	output logic                    timer_irq_o,
	output logic [NUM_OBJ-1:0]      object_busy_o
);

	typedef struct packed {
		logic [6:0]         gif;
		logic [7:0]         gie;
		logic [NUM_OBJ-1:0] busy;
		logic [NUM_OBJ-1:0] oie;
		logic [NUM_OBJ-1:0] ois;
		logic               boff_prev;
		logic               errp_prev;
		logic [15:0]        timer_prev;
		logic               timer_valid;
		logic [7:0]         rdata;
		logic               can_irq;
		logic               timer_irq;
	} canis_state_t;

	canis_state_t state_r;
	canis_state_t state_nxt;

	logic [6:0]         gif_set;
	logic [6:0]         gif_clr;
	logic               summary;
	logic               can_req;
	logic [NUM_OBJ-1:0] obj_src;
	logic [7:0]         rd_mux;
	logic [15:0]        oie_word;
	logic [15:0]        ois_word;
	logic [15:0]        busy_word;

	// object-level source: any enabled kind of flag on that object
	genvar g;
	generate
		for (g = 0; g < NUM_OBJ; g++) begin : g_obj
			assign obj_src[g] = (receive_complete_flag_i[g] & state_r.gie[CANIS_GIE_RX])
				| (transmit_complete_flag_i[g] & state_r.gie[CANIS_GIE_TX])
				| (object_error_flag_i[g] & state_r.gie[CANIS_GIE_OERR]);
		end
	endgenerate

	assign oie_word  = {{(16 - NUM_OBJ){1'b0}}, state_r.oie};
	assign ois_word  = {{(16 - NUM_OBJ){1'b0}}, state_r.ois};
	assign busy_word = {{(16 - NUM_OBJ){1'b0}}, state_r.busy};

	// summary excludes the timer overrun bit
	assign summary = (|{state_r.gif[CANIS_GIF_BOFF], state_r.gif[4:0]}) | (|state_r.ois);

	always_comb begin
		gif_set = '0;
		// bus-off only counts when arriving from error passive
		gif_set[CANIS_GIF_BOFF]  = bus_off_i & ~state_r.boff_prev & state_r.errp_prev;
		gif_set[CANIS_GIF_OVRT]  = state_r.timer_valid && state_r.timer_prev == CANIS_TIMER_MAX
			&& timer_value_i == 16'h0000;
		gif_set[CANIS_GIF_FBUF]  = frame_buffer_done_i;
		// these inputs carry only errors not yet matched to an object
		gif_set[CANIS_GIF_STUFF] = general_stuff_error_i;
		gif_set[CANIS_GIF_CRC]   = general_crc_error_i;
		gif_set[CANIS_GIF_FORM]  = general_form_error_i;
		gif_set[CANIS_GIF_ACK]   = general_ack_error_i;

		gif_clr = '0;
		if (reg_wr_i && reg_addr_i == CANIS_OFF_GIF) begin
			gif_clr = reg_wdata_i[6:0];
		end
		// a refused buffer clear leaves the flag standing
		gif_clr[CANIS_GIF_FBUF] = gif_clr[CANIS_GIF_FBUF] & buffer_config_rewritten_i;
		gif_clr[CANIS_GIF_OVRT] = gif_clr[CANIS_GIF_OVRT] | timer_handler_ack_i;
	end

	always_comb begin
		case (reg_addr_i)
			CANIS_OFF_GIF:  rd_mux = {summary, state_r.gif};
			CANIS_OFF_GIE:  rd_mux = state_r.gie;
			CANIS_OFF_BSYL: rd_mux = busy_word[7:0];
			CANIS_OFF_BSYH: rd_mux = busy_word[15:8];
			CANIS_OFF_OIEL: rd_mux = oie_word[7:0];
			CANIS_OFF_OIEH: rd_mux = oie_word[15:8];
			CANIS_OFF_OISL: rd_mux = ois_word[7:0];
			CANIS_OFF_OISH: rd_mux = ois_word[15:8];
			default:        rd_mux = 8'h00;
		endcase
	end

	assign can_req = state_r.gie[CANIS_GIE_MASTER] & (
		(state_r.gif[CANIS_GIF_BOFF] & state_r.gie[CANIS_GIE_BOFF])
		| (state_r.gif[CANIS_GIF_FBUF] & state_r.gie[CANIS_GIE_FBUF])
		| ((|state_r.gif[3:0]) & state_r.gie[CANIS_GIE_GERR])
		| (|(state_r.ois & state_r.oie)));

	always_comb begin
		state_nxt = state_r;
		// set wins over a clear in the same cycle
		state_nxt.gif = (state_r.gif & ~gif_clr) | gif_set;
		state_nxt.boff_prev   = bus_off_i;
		state_nxt.errp_prev   = error_passive_i;
		state_nxt.timer_prev  = timer_value_i;
		state_nxt.timer_valid = 1'b1;
		if (reg_wr_i && reg_addr_i == CANIS_OFF_GIE) begin
			state_nxt.gie = reg_wdata_i;
		end
		if (reg_wr_i && reg_addr_i == CANIS_OFF_OIEL) begin
			// reserved upper bits are dropped whatever software writes
			state_nxt.oie = reg_wdata_i[NUM_OBJ-1:0];
		end
		for (int i = 0; i < NUM_OBJ; i++) begin
			if (abort_request_i || standby_i || object_disable_cfg_i[i]
				|| transmit_complete_flag_i[i] || receive_complete_flag_i[i]) begin
				state_nxt.busy[i] = 1'b0;
			end else if (object_enable_cfg_i[i]) begin
				state_nxt.busy[i] = 1'b1;
			end
		end
		// pending bit follows the object's enabled flags as long as they stand
		state_nxt.ois = obj_src;
		state_nxt.rdata = reg_rd_i ? rd_mux : 8'h00;
		state_nxt.can_irq = can_req;
		state_nxt.timer_irq = state_r.gif[CANIS_GIF_OVRT] & state_r.gie[CANIS_GIE_OVRT];
		if (sys_rst_i) begin
			state_nxt = '0;
			state_nxt.gif = CANIS_GIF_RST[6:0];
			state_nxt.gie = CANIS_GIE_RST;
		end
	end

	always_ff @(posedge clk_i) begin
		state_r <= state_nxt;
	end

	assign reg_rdata_o   = state_r.rdata;
	assign can_irq_o     = state_r.can_irq;
	assign timer_irq_o   = state_r.timer_irq;
	assign object_busy_o = state_r.busy;

	// assertions
	a_boff_entry_only: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(state_r.gif[CANIS_GIF_BOFF]) |-> $past(bus_off_i) && !$past(state_r.boff_prev)
		&& $past(state_r.errp_prev))
		else $error("bus-off flag set without entry from error passive");

	a_gif_w1c_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == CANIS_OFF_GIF && reg_wdata_i[CANIS_GIF_STUFF] && !general_stuff_error_i
		|=> !state_r.gif[CANIS_GIF_STUFF])
		else $error("stuff flag not cleared by write one");

	a_gif_w0_keeps: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == CANIS_OFF_GIF && !reg_wdata_i[CANIS_GIF_ACK] && state_r.gif[CANIS_GIF_ACK]
		|=> state_r.gif[CANIS_GIF_ACK])
		else $error("ack flag lost on write zero");

	a_ovrt_rollover: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		state_r.timer_valid && state_r.timer_prev == 16'hffff && timer_value_i == 16'h0000
		|=> state_r.gif[CANIS_GIF_OVRT])
		else $error("timer overrun flag missed rollover");

	a_ovrt_handler: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		timer_handler_ack_i && !gif_set[CANIS_GIF_OVRT] |=> !state_r.gif[CANIS_GIF_OVRT])
		else $error("timer overrun flag not cleared by handler entry");

	a_fbuf_guard: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		state_r.gif[CANIS_GIF_FBUF] && !buffer_config_rewritten_i |=> state_r.gif[CANIS_GIF_FBUF])
		else $error("frame buffer flag cleared before config rewrite");

	a_busy_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		abort_request_i || standby_i |=> object_busy_o == '0)
		else $error("busy bits survive abort or standby");

	a_busy_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		object_enable_cfg_i[0] && !abort_request_i && !standby_i && !object_disable_cfg_i[0]
		&& !transmit_complete_flag_i[0] && !receive_complete_flag_i[0] |=> object_busy_o[0])
		else $error("busy bit not set on enable");

	a_timer_irq_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		timer_irq_o |-> $past(state_r.gie[CANIS_GIE_OVRT]) && $past(state_r.gif[CANIS_GIF_OVRT]))
		else $error("timer irq without flag and enable");

	a_can_irq_master: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!state_r.gie[CANIS_GIE_MASTER] |=> !can_irq_o)
		else $error("can irq raised with master enable off");

	a_summary_excl: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_rd_i && reg_addr_i == CANIS_OFF_GIF && state_r.gif == 7'h20 && state_r.ois == '0
		|=> !reg_rdata_o[CANIS_GIF_SUMMARY])
		else $error("summary flag counts timer overrun");

	a_ois_tracks: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		receive_complete_flag_i[1] && state_r.gie[CANIS_GIE_RX] |=> state_r.ois[1])
		else $error("object pending bit missed enabled receive");

	a_ois_tx: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		transmit_complete_flag_i[0] && state_r.gie[CANIS_GIE_TX] |=> state_r.ois[0])
		else $error("object pending bit missed enabled transmit");

	a_ois_err: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		object_error_flag_i[5] && state_r.gie[CANIS_GIE_OERR] |=> state_r.ois[5])
		else $error("object pending bit missed enabled object error");

	a_ois_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!(|(receive_complete_flag_i | transmit_complete_flag_i | object_error_flag_i)) |=> state_r.ois == '0)
		else $error("object pending bit without object flag");

	// each general source lands in its own flag one cycle later
	a_fbuf_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		frame_buffer_done_i |=> state_r.gif[CANIS_GIF_FBUF])
		else $error("frame buffer flag missed completion");

	a_stuff_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		general_stuff_error_i |=> state_r.gif[CANIS_GIF_STUFF])
		else $error("stuff flag missed error");

	a_crc_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		general_crc_error_i |=> state_r.gif[CANIS_GIF_CRC])
		else $error("crc flag missed error");

	a_form_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		general_form_error_i |=> state_r.gif[CANIS_GIF_FORM])
		else $error("form flag missed error");

	a_ack_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		general_ack_error_i |=> state_r.gif[CANIS_GIF_ACK])
		else $error("ack flag missed error");

	a_obj_err_no_gen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!general_stuff_error_i && !general_crc_error_i && !general_form_error_i && !general_ack_error_i
		&& state_r.gif[3:0] == 4'h0 |=> state_r.gif[3:0] == 4'h0)
		else $error("general error flag set without general error");

	a_boff_no_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!(bus_off_i && !state_r.boff_prev && state_r.errp_prev) && !state_r.gif[CANIS_GIF_BOFF]
		|=> !state_r.gif[CANIS_GIF_BOFF])
		else $error("bus-off flag set with no entry");

	a_ovrt_no_spur: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!(state_r.timer_valid && state_r.timer_prev == 16'hffff && timer_value_i == 16'h0000)
		&& !state_r.gif[CANIS_GIF_OVRT] |=> !state_r.gif[CANIS_GIF_OVRT])
		else $error("timer overrun flag set without rollover");

	// software clears: write one clears, write zero keeps
	a_gif_w1c_boff: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == CANIS_OFF_GIF && reg_wdata_i[CANIS_GIF_BOFF] && !bus_off_i
		|=> !state_r.gif[CANIS_GIF_BOFF])
		else $error("bus-off flag not cleared by write one");

	a_gif_w1c_crc: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == CANIS_OFF_GIF && reg_wdata_i[CANIS_GIF_CRC] && !general_crc_error_i
		|=> !state_r.gif[CANIS_GIF_CRC])
		else $error("crc flag not cleared by write one");

	a_gif_w0_boff: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == CANIS_OFF_GIF && !reg_wdata_i[CANIS_GIF_BOFF] && state_r.gif[CANIS_GIF_BOFF]
		|=> state_r.gif[CANIS_GIF_BOFF])
		else $error("bus-off flag lost on write zero");

	a_fbuf_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == CANIS_OFF_GIF && reg_wdata_i[CANIS_GIF_FBUF] && buffer_config_rewritten_i
		&& !frame_buffer_done_i |=> !state_r.gif[CANIS_GIF_FBUF])
		else $error("frame buffer flag not cleared after config rewrite");

	a_gie_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == CANIS_OFF_GIE |=> state_r.gie == $past(reg_wdata_i))
		else $error("enable register write lost");

	a_oie_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == CANIS_OFF_OIEL |=> state_r.oie == $past(reg_wdata_i[NUM_OBJ-1:0]))
		else $error("object enable write lost");

	a_oie_high_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_rd_i && reg_addr_i == CANIS_OFF_OIEH |=> reg_rdata_o == 8'h00)
		else $error("reserved object enable bits read nonzero");

	a_ois_high_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_rd_i && reg_addr_i == CANIS_OFF_OISH |=> reg_rdata_o == 8'h00)
		else $error("reserved pending bits read nonzero");

	a_rdata_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data outside read cycle");

	a_summary_incl: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reg_rd_i && reg_addr_i == CANIS_OFF_GIF && (state_r.gif[CANIS_GIF_BOFF] || (|state_r.gif[4:0])
		|| (|state_r.ois)) |=> reg_rdata_o[CANIS_GIF_SUMMARY])
		else $error("summary flag misses a pending source");

	// busy bits: completion and disable
	a_busy_txclr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		transmit_complete_flag_i[0] |=> !object_busy_o[0])
		else $error("busy bit survives transmit complete");

	a_busy_rxclr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		receive_complete_flag_i[1] |=> !object_busy_o[1])
		else $error("busy bit survives receive complete");

	a_busy_dis: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		object_disable_cfg_i[2] |=> !object_busy_o[2])
		else $error("busy bit survives disable config");

	a_can_irq_src: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		can_irq_o |-> $past(state_r.gie[CANIS_GIE_MASTER]))
		else $error("can irq without master enable");

	a_can_irq_fbuf: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		state_r.gie[CANIS_GIE_MASTER] && state_r.gie[CANIS_GIE_FBUF] && state_r.gif[CANIS_GIF_FBUF]
		|=> can_irq_o)
		else $error("can irq missing for enabled frame buffer flag");

	a_timer_irq_own: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		state_r.gif[CANIS_GIF_OVRT] && state_r.gie[CANIS_GIE_OVRT] |=> timer_irq_o)
		else $error("timer irq missing with flag and enable");

	a_timer_irq_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!state_r.gie[CANIS_GIE_OVRT] |=> !timer_irq_o)
		else $error("timer irq with its enable off");

endmodule : canis_core

`default_nettype wire

// ===== logic/canis_pkg.sv
// package: register map, field positions and reset values of the CAN interrupt status block
package canis_pkg;

	// register offsets on the plain register port
	localparam logic [2:0] CANIS_OFF_GIF   = 3'h0;
	localparam logic [2:0] CANIS_OFF_GIE   = 3'h1;
	localparam logic [2:0] CANIS_OFF_BSYL  = 3'h2;
	localparam logic [2:0] CANIS_OFF_BSYH  = 3'h3;
	localparam logic [2:0] CANIS_OFF_OIEL  = 3'h4;
	localparam logic [2:0] CANIS_OFF_OIEH  = 3'h5;
	localparam logic [2:0] CANIS_OFF_OISL  = 3'h6;
	localparam logic [2:0] CANIS_OFF_OISH  = 3'h7;

	// general flag register fields
	localparam int CANIS_GIF_SUMMARY = 7;
	localparam int CANIS_GIF_BOFF    = 6;
	localparam int CANIS_GIF_OVRT    = 5;
	localparam int CANIS_GIF_FBUF    = 4;
	localparam int CANIS_GIF_STUFF   = 3;
	localparam int CANIS_GIF_CRC     = 2;
	localparam int CANIS_GIF_FORM    = 1;
	localparam int CANIS_GIF_ACK     = 0;

	// general enable register fields
	localparam int CANIS_GIE_MASTER  = 7;
	localparam int CANIS_GIE_BOFF    = 6;
	localparam int CANIS_GIE_RX      = 5;
	localparam int CANIS_GIE_TX      = 4;
	localparam int CANIS_GIE_OERR    = 3;
	localparam int CANIS_GIE_FBUF    = 2;
	localparam int CANIS_GIE_GERR    = 1;
	localparam int CANIS_GIE_OVRT    = 0;

	// reset values
	localparam logic [7:0] CANIS_GIF_RST  = 8'h00;
	localparam logic [7:0] CANIS_GIE_RST  = 8'h00;
	localparam logic [7:0] CANIS_BYTE_RST = 8'h00;

	// timer rollover point
	localparam logic [15:0] CANIS_TIMER_MAX = 16'hffff;

endpackage : canis_pkg

// ===== tb/canis_engine_model.sv
// protocol engine stand-in: fault confinement state and the CAN timer, which counts only while load_i is low
`timescale 1ns/100ps
`default_nettype none

module canis_engine_model #(
	parameter logic [15:0] LOAD_VAL = 16'hfffe
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// commands from the bench
	input  wire logic        load_i,
	input  wire logic [1:0]  state_i,
	// engine outputs
	output logic      [15:0] timer_value_o,
	output logic             error_passive_o,
	output logic             bus_off_o
);
	logic [1:0] st_r;

	// timer held at a preset until released, so it wraps only when a test asks for it
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			timer_value_o <= LOAD_VAL;
			st_r          <= 2'h0;
		end else begin
			timer_value_o <= load_i ? LOAD_VAL : timer_value_o + 16'h0001;
			st_r          <= state_i;
		end
	end

	assign error_passive_o = (st_r == 2'h1);
	assign bus_off_o       = (st_r == 2'h2);
endmodule // canis_engine_model
`default_nettype wire

// ===== tb/canis_core_bench.sv
// self-checking bench of the CAN interrupt status block
`timescale 1ns/100ps
`default_nettype none

module canis_core_bench;
	import canis_pkg::*;
	logic        clk_i = 1'h0, sys_rst_i = 1'h1, wr = 1'h0, rd = 1'h0, hack = 1'h0, fbd = 1'h0;
	logic        rew = 1'h0, abrt = 1'h0, stby = 1'h0, tld = 1'h1, cirq, tirq, ep, bo;
	logic [1:0]  st = 2'h0;
	logic [2:0]  addr = 3'h0;
	logic [3:0]  gerr = 4'h0;
	logic [5:0]  enc = 6'h00, dis = 6'h00, txf = 6'h00, rxf = 6'h00, errf = 6'h00, busy;
	logic [7:0]  wd = 8'h00, rdat;
	logic [15:0] tv;
	int          errors = 0, n_compared = 0;

	canis_engine_model ENG (.clk_i, .sys_rst_i, .load_i(tld), .state_i(st), .timer_value_o(tv),
		.error_passive_o(ep), .bus_off_o(bo));
	canis_core #(.NUM_OBJ(6)) DUT (.clk_i, .sys_rst_i, .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdat), .error_passive_i(ep), .bus_off_i(bo), .timer_value_i(tv),
		.timer_handler_ack_i(hack), .frame_buffer_done_i(fbd), .buffer_config_rewritten_i(rew),
		.general_stuff_error_i(gerr[3]), .general_crc_error_i(gerr[2]), .general_form_error_i(gerr[1]),
		.general_ack_error_i(gerr[0]), .object_enable_cfg_i(enc), .object_disable_cfg_i(dis),
		.transmit_complete_flag_i(txf), .receive_complete_flag_i(rxf), .object_error_flag_i(errf),
		.abort_request_i(abrt), .standby_i(stby), .can_irq_o(cirq), .timer_irq_o(tirq), .object_busy_o(busy));

	initial forever #10 clk_i = ~clk_i;

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wd <= d;
		wr <= 1'h1;
		@(posedge clk_i);
		wr <= 1'h0;
	endtask
	// read data stand only in the cycle after the strobe, so they are taken just past that edge
	task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk_i);
		rd <= 1'h0;
		#1 chk(rdat, e);
	endtask

	task automatic t_reset;
		for (int a = 0; a < 8; a++) rd_reg(a[2:0], 8'h00);
	endtask
	task automatic t_gen_err;
		for (int b = 0; b < 4; b++) begin
			@(posedge clk_i);
			gerr <= 4'h1 << b;
			@(posedge clk_i);
			gerr <= 4'h0;
			rd_reg(CANIS_OFF_GIF, 8'h80 | (8'h01 << b));
			wr_reg(CANIS_OFF_GIF, 8'h00);
			rd_reg(CANIS_OFF_GIF, 8'h80 | (8'h01 << b));
			wr_reg(CANIS_OFF_GIF, 8'h01 << b);
			rd_reg(CANIS_OFF_GIF, 8'h00);
		end
	endtask
	task automatic t_enables;
		wr_reg(CANIS_OFF_GIE, 8'h7e);
		rd_reg(CANIS_OFF_GIE, 8'h7e);
		@(posedge clk_i);
		gerr <= 4'h8;
		@(posedge clk_i);
		gerr <= 4'h0;
		cyc(3);
		chk(cirq, 1'h0);
		wr_reg(CANIS_OFF_GIE, 8'h82);
		cyc(3);
		chk(cirq, 1'h1);
		wr_reg(CANIS_OFF_GIF, 8'h08);
		cyc(3);
		chk(cirq, 1'h0);
		wr_reg(CANIS_OFF_GIE, 8'h00);
	endtask
	task automatic t_bus_off;
		@(posedge clk_i) st <= 2'h1;
		cyc(2);
		st <= 2'h2;
		cyc(3);
		rd_reg(CANIS_OFF_GIF, 8'hc0);
		wr_reg(CANIS_OFF_GIF, 8'h40);
		st <= 2'h0;
		cyc(3);
		st <= 2'h2;
		cyc(3);
		rd_reg(CANIS_OFF_GIF, 8'h00);
		st <= 2'h0;
	endtask
	task automatic t_timer;
		wr_reg(CANIS_OFF_GIE, 8'h01);
		tld <= 1'h0;
		cyc(5);
		tld <= 1'h1;
		rd_reg(CANIS_OFF_GIF, 8'h20);
		chk(tirq, 1'h1);
		chk(cirq, 1'h0);
		@(posedge clk_i) hack <= 1'h1;
		@(posedge clk_i) hack <= 1'h0;
		rd_reg(CANIS_OFF_GIF, 8'h00);
		cyc(2);
		chk(tirq, 1'h0);
		wr_reg(CANIS_OFF_GIE, 8'h00);
	endtask
	task automatic t_fbuf;
		@(posedge clk_i) fbd <= 1'h1;
		@(posedge clk_i) fbd <= 1'h0;
		rd_reg(CANIS_OFF_GIF, 8'h90);
		wr_reg(CANIS_OFF_GIF, 8'h10);
		rd_reg(CANIS_OFF_GIF, 8'h90);
		rew <= 1'h1;
		wr_reg(CANIS_OFF_GIF, 8'h10);
		rd_reg(CANIS_OFF_GIF, 8'h00);
		rew <= 1'h0;
	endtask
	task automatic t_busy;
		@(posedge clk_i) enc <= 6'h3f;
		@(posedge clk_i) enc <= 6'h00;
		rd_reg(CANIS_OFF_BSYL, 8'h3f);
		txf <= 6'h01;
		rxf <= 6'h02;
		dis <= 6'h04;
		@(posedge clk_i) dis <= 6'h00;
		rd_reg(CANIS_OFF_BSYL, 8'h38);
		txf <= 6'h00;
		rxf <= 6'h00;
		abrt <= 1'h1;
		cyc(2);
		chk({2'h0, busy}, 8'h00);
		abrt <= 1'h0;
		enc <= 6'h3f;
		@(posedge clk_i) enc <= 6'h00;
		stby <= 1'h1;
		cyc(2);
		rd_reg(CANIS_OFF_BSYL, 8'h00);
		rd_reg(CANIS_OFF_BSYH, 8'h00);
		stby <= 1'h0;
	endtask
	task automatic t_obj;
		wr_reg(CANIS_OFF_OIEL, 8'h3f);
		wr_reg(CANIS_OFF_OIEH, 8'h00);
		rd_reg(CANIS_OFF_OIEL, 8'h3f);
		wr_reg(CANIS_OFF_GIE, 8'h20);
		rxf <= 6'h04;
		txf <= 6'h01;
		errf <= 6'h20;
		cyc(2);
		rd_reg(CANIS_OFF_OISL, 8'h04);
		rd_reg(CANIS_OFF_GIF, 8'h80);
		wr_reg(CANIS_OFF_GIE, 8'ha0);
		cyc(3);
		chk(cirq, 1'h1);
		wr_reg(CANIS_OFF_GIE, 8'h18);
		cyc(2);
		rd_reg(CANIS_OFF_OISL, 8'h21);
		rxf <= 6'h00;
		txf <= 6'h00;
		errf <= 6'h00;
		wr_reg(CANIS_OFF_GIE, 8'h00);
	endtask

	task automatic tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		cyc(16);
		sys_rst_i <= 1'h0;
		t_reset;
		t_gen_err;
		t_enables;
		t_bus_off;
		t_timer;
		t_fbuf;
		t_busy;
		t_obj;
		tally_and_finish;
	end
	// the sequence needs well under a thousand cycles; a hang is cut at twenty thousand
	initial begin
		#400000;
		errors++;
		tally_and_finish;
	end
endmodule // canis_core_bench
`default_nettype wire
